//--- hdl/pxmap_pkg.sv
package pxmap_pkg;

  // register map of the plain register port
  localparam int PXMAP_ADDR_W = 4;
  localparam logic [3:0] PXMAP_REG_IFACE = 4'h0;
  localparam logic [3:0] PXMAP_REG_SKEW = 4'h1;
  localparam logic [3:0] PXMAP_REG_STATUS = 4'h2;

  // interface_config_reg fields
  localparam int PXMAP_IF_BUS_WIDTH = 0;
  localparam int PXMAP_IF_CLOCK_MODE = 1;
  localparam int PXMAP_IF_LATCH_EDGE = 2;
  localparam logic [2:0] PXMAP_IF_RESET = 3'h0;

  // skew_config_reg fields
  localparam int PXMAP_SK_ENABLE = 0;
  localparam int PXMAP_SK_CODE_LSB = 1;
  localparam logic [3:0] PXMAP_SK_RESET = 4'h0;

  // skew multiplier is code minus this centre
  localparam logic signed [3:0] PXMAP_SKEW_CENTER = 4'sh4;
  localparam int PXMAP_SKEW_STEP_PS = 350;

  // tmds control characters, indexed by {c1, c0}
  localparam logic [9:0] PXMAP_CTRL_00 = 10'h354;
  localparam logic [9:0] PXMAP_CTRL_01 = 10'h0AB;
  localparam logic [9:0] PXMAP_CTRL_10 = 10'h154;
  localparam logic [9:0] PXMAP_CTRL_11 = 10'h2AB;

  typedef struct packed {
    logic bus24;
    logic edge_rise;
    logic diff;
    logic skew_en;
    logic [2:0] skew_code;
  } pxmap_cfg_s;

  // config pins, all asynchronous to clock_i
  typedef struct packed {
    logic host_bus;
    logic low_swing;
    logic bus_width;
    logic clock_mode;
    logic latch_edge;
    logic skew_en;
    logic [2:0] skew_code;
  } pxmap_pins_s;

  typedef struct packed {
    logic [23:0] data;
    logic de;
    logic hsync;
    logic vsync;
    logic [2:0] aux;
  } pxmap_cap_s;

  typedef struct packed {
    logic signed [4:0] disp;
    logic [9:0] sym;
  } pxmap_tmds_s;

endpackage

//--- hdl/pxmap_top.sv
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// R1 - pick one of two tmds characters from running ones/zeros tally for dc balance
// R2 - active video: red bits 23:16 on lane 2, green 15:8 lane 1, blue 7:0 lane 0
// R3 - blanking: aux 3:2 on lane 2, aux 1 on lane 1, syncs on lane 0
// R4 - aux controls are encoded and carried during vertical blanking
// R5 - controller holds aux controls and syncs stable while data-enable is high
// R6 - differential mode captures data, enable and syncs at clock-pair crossover
// R7 - single-ended mode: clock on positive input, negative input grounded
// R8 - bus width 0 gives 12-bit dual-edge, 1 gives 24-bit single-edge capture
// R9 - latch edge 1 is rising, 0 falling; primary edge in 12-bit mode
// R10 - 12-bit mode captures a half-word on every clock edge
// R11 - low swing: clock mode decoded per width, inverted between 12 and 24 bit
// R12 - high swing ignores clock mode and always captures single-ended
// R13 - selects come from registers when host bus enabled, else from pins
// R14 - first half: green 3:0 and blue; second half: red and green 7:4
// R15 - single-ended clocking in low swing is discouraged, advice only
// R16 - skew enable and three-bit code shift capture time against the clock
// R17 - capture offset is code minus four steps, clock itself unchanged
// R18 - two half-words form one pixel per period, aligned with enable and syncs
module pxmap_top
  import pxmap_pkg::*;
#(
  parameter int ADDR_W = PXMAP_ADDR_W
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  input wire pxmap_pins_s cfg_pins_i,
  output logic diff_clock_o,
  output logic signed [3:0] skew_offset_o,
  input wire logic pixel_clock_pair_i,
  input wire logic [23:0] pix_data_i,
  input wire logic pix_de_i,
  input wire logic pix_hsync_i,
  input wire logic pix_vsync_i,
  input wire logic [2:0] aux_control_inputs_i,
  output logic [9:0] red_lane_o,
  output logic [9:0] green_lane_o,
  output logic [9:0] blue_lane_o
);

  initial begin
    if (ADDR_W < 2) begin
      $error("ADDR_W must be at least 2");
    end
  end

  // ---------------- register side, clock_i ----------------
  typedef struct packed {
    logic rst_q;
    pxmap_pins_s pins_meta;
    pxmap_pins_s pins;
    logic [2:0] iface;
    logic [3:0] skew;
    pxmap_cfg_s cfg;
    logic [7:0] rdata;
  } pxmap_sys_s;

  pxmap_sys_s sys_reg;
  pxmap_sys_s sys_next;
  pxmap_cfg_s cfg_eff;

  always_comb begin
    cfg_eff = '0;
    if (sys_reg.pins.host_bus) begin // R13
      cfg_eff.bus24 = sys_reg.iface[PXMAP_IF_BUS_WIDTH];
      cfg_eff.edge_rise = sys_reg.iface[PXMAP_IF_LATCH_EDGE];
      cfg_eff.diff = sys_reg.iface[PXMAP_IF_CLOCK_MODE];
      cfg_eff.skew_en = sys_reg.skew[PXMAP_SK_ENABLE];
      cfg_eff.skew_code = sys_reg.skew[PXMAP_SK_CODE_LSB +: 3];
    end else begin
      cfg_eff.bus24 = sys_reg.pins.bus_width;
      cfg_eff.edge_rise = sys_reg.pins.latch_edge;
      cfg_eff.diff = sys_reg.pins.clock_mode;
      cfg_eff.skew_en = sys_reg.pins.skew_en;
      cfg_eff.skew_code = sys_reg.pins.skew_code;
    end
    // clock mode select: meaning flips with width, dead in high swing
    if (!sys_reg.pins.low_swing) begin
      cfg_eff.diff = 1'b0; // R12
    end else if (!cfg_eff.bus24) begin
      cfg_eff.diff = ~cfg_eff.diff; // R11
    end
  end

  always_comb begin
    sys_next = sys_reg;
    sys_next.rst_q = rst_n_i;
    sys_next.pins_meta = cfg_pins_i;
    sys_next.pins = sys_reg.pins_meta;
    sys_next.cfg = cfg_eff;
    sys_next.rdata = '0;
    if (bus_wr_i && bus_addr_i == ADDR_W'(PXMAP_REG_IFACE)) begin
      sys_next.iface = bus_wdata_i[2:0];
    end
    if (bus_wr_i && bus_addr_i == ADDR_W'(PXMAP_REG_SKEW)) begin
      sys_next.skew = bus_wdata_i[3:0];
    end
    if (bus_rd_i) begin
      case (bus_addr_i)
        ADDR_W'(PXMAP_REG_IFACE): sys_next.rdata = {5'h00, sys_reg.iface};
        ADDR_W'(PXMAP_REG_SKEW): sys_next.rdata = {4'h0, sys_reg.skew};
        ADDR_W'(PXMAP_REG_STATUS): sys_next.rdata = {1'b0, sys_reg.cfg};
        default: sys_next.rdata = '0;
      endcase
    end
    if (!rst_n_i) begin
      sys_next.iface = PXMAP_IF_RESET;
      sys_next.skew = PXMAP_SK_RESET;
      sys_next.cfg = '0;
      sys_next.rdata = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    sys_reg <= sys_next;
  end

  assign bus_rdata_o = sys_reg.rdata;
  // crossover timing is done by the pad receiver; we only steer it
  assign diff_clock_o = sys_reg.cfg.diff; // R6
  // drives the analog delay line; disabled means centre setting
  assign skew_offset_o = sys_reg.cfg.skew_en ?
    $signed({1'b0, sys_reg.cfg.skew_code}) - PXMAP_SKEW_CENTER : 4'sh0; // R16 R17

  // ---------------- link side, pixel clock ----------------
  function automatic pxmap_tmds_s tmds_encode(input logic [7:0] d, input logic signed [4:0] disp);
    pxmap_tmds_s r;
    logic [8:0] qm;
    logic [3:0] n1d;
    logic signed [4:0] bal;
    logic use_xnor;
    r = '0;
    n1d = '0;
    for (int i = 0; i < 8; i++) begin
      n1d = n1d + 4'(d[i]);
    end
    use_xnor = (n1d > 4'h4) || (n1d == 4'h4 && !d[0]);
    qm = '0;
    qm[0] = d[0];
    for (int i = 1; i < 8; i++) begin
      qm[i] = use_xnor ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
    end
    qm[8] = ~use_xnor;
    // bal = ones minus zeros of the eight coded bits qm[7:0]
    bal = -5'sh8;
    for (int i = 0; i < 8; i++) begin
      bal = bal + (qm[i] ? 5'sh2 : 5'sh0);
    end
    if (disp == 5'sh0 || bal == 5'sh0) begin
      r.sym = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
      r.disp = qm[8] ? disp + bal : disp - bal;
    end else if ((disp > 5'sh0 && bal > 5'sh0) || (disp < 5'sh0 && bal < 5'sh0)) begin
      r.sym = {1'b1, qm[8], ~qm[7:0]};
      r.disp = disp + (qm[8] ? 5'sh2 : 5'sh0) - bal;
    end else begin
      r.sym = {1'b0, qm[8], qm[7:0]};
      r.disp = disp - (qm[8] ? 5'sh0 : 5'sh2) + bal;
    end
    return r;
  endfunction

  function automatic logic [9:0] ctrl_code(input logic [1:0] c);
    case (c)
      2'b00: return PXMAP_CTRL_00;
      2'b01: return PXMAP_CTRL_01;
      2'b10: return PXMAP_CTRL_10;
      default: return PXMAP_CTRL_11;
    endcase
  endfunction

  typedef struct packed {
    logic [1:0] rst_sync;
    pxmap_cfg_s cfg_meta;
    pxmap_cfg_s cfg_sync;
    pxmap_cfg_s cfg;
    pxmap_cap_s rise;
    pxmap_cap_s fall_q;
    pxmap_cap_s pix;
    logic [2:0][4:0] disp;
    logic [2:0][9:0] lane;
  } pxmap_link_s;

  pxmap_link_s link_reg;
  pxmap_link_s link_next;
  pxmap_cap_s fall_reg;
  pxmap_cap_s pin_cap;
  logic link_run;
  logic [2:0][7:0] lane_byte;
  logic [2:0][1:0] lane_ctrl;

  assign link_run = link_reg.rst_sync[1];

  always_comb begin
    pin_cap.data = pix_data_i;
    pin_cap.de = pix_de_i;
    pin_cap.hsync = pix_hsync_i;
    pin_cap.vsync = pix_vsync_i;
    pin_cap.aux = aux_control_inputs_i;
  end

  // secondary half in 12-bit rising, primary half in 12-bit falling, the only edge in 24-bit falling
  always_ff @(negedge pixel_clock_pair_i) begin
    fall_reg <= link_run ? pin_cap : '0; // R10
  end

  always_comb begin
    lane_byte[2] = link_reg.pix.data[23:16]; // R2
    lane_byte[1] = link_reg.pix.data[15:8];
    lane_byte[0] = link_reg.pix.data[7:0];
    lane_ctrl[2] = link_reg.pix.aux[2:1]; // R3 R4
    lane_ctrl[1] = {1'b0, link_reg.pix.aux[0]};
    lane_ctrl[0] = {link_reg.pix.vsync, link_reg.pix.hsync};
  end

  always_comb begin
    pxmap_tmds_s enc;
    enc = '0;
    link_next = link_reg;
    link_next.rst_sync = {link_reg.rst_sync[0], sys_reg.rst_q};
    link_next.cfg_meta = sys_reg.cfg;
    link_next.cfg_sync = link_reg.cfg_meta;
    // multi-bit word: take it only once two samples agree, never a torn mix
    if (link_reg.cfg_sync == link_reg.cfg_meta) begin
      link_next.cfg = link_reg.cfg_sync;
    end
    link_next.rise = pin_cap;
    link_next.fall_q = fall_reg;
    if (link_reg.cfg.bus24) begin // R8
      link_next.pix = link_reg.cfg.edge_rise ? link_reg.rise : link_reg.fall_q; // R9
    end else if (link_reg.cfg.edge_rise) begin
      // primary rising half, secondary falling half just after it
      link_next.pix = link_reg.rise; // R18
      link_next.pix.data = {fall_reg.data[11:0], link_reg.rise.data[11:0]}; // R14
    end else begin
      link_next.pix = link_reg.fall_q; // R18
      link_next.pix.data = {link_reg.rise.data[11:0], link_reg.fall_q.data[11:0]}; // R14
    end
    for (int ch = 0; ch < 3; ch++) begin
      if (link_reg.pix.de) begin
        enc = tmds_encode(lane_byte[ch], $signed(link_reg.disp[ch])); // R1
        link_next.lane[ch] = enc.sym;
        link_next.disp[ch] = enc.disp;
      end else begin
        link_next.lane[ch] = ctrl_code(lane_ctrl[ch]); // R3
        link_next.disp[ch] = '0; // R1
      end
    end
    if (!link_run) begin
      link_next.cfg = '0;
      link_next.rise = '0;
      link_next.fall_q = '0;
      link_next.pix = '0;
      link_next.disp = '0;
      link_next.lane = '0;
    end
  end

  always_ff @(posedge pixel_clock_pair_i) begin
    link_reg <= link_next;
  end

  assign red_lane_o = link_reg.lane[2];
  assign green_lane_o = link_reg.lane[1];
  assign blue_lane_o = link_reg.lane[0];

  // ---------------- checks ----------------
  sequence s_blank_pix;
    link_run && !link_reg.pix.de;
  endsequence

  sequence s_active_pix;
    link_run && link_reg.pix.de;
  endsequence

  chk_sync_lane_ctrl: assert property (@(posedge pixel_clock_pair_i) disable iff (!rst_n_i) // R3
    s_blank_pix |=> blue_lane_o == ctrl_code({$past(link_reg.pix.vsync), $past(link_reg.pix.hsync)}))
    else $error("blue lane does not carry sync control code");

  chk_aux_lane_ctrl: assert property (@(posedge pixel_clock_pair_i) disable iff (!rst_n_i) // R4
    s_blank_pix |=> red_lane_o == ctrl_code($past(link_reg.pix.aux[2:1]))
      && green_lane_o == ctrl_code({1'b0, $past(link_reg.pix.aux[0])}))
    else $error("aux controls not on red and green lanes");

  chk_disp_bounded: assert property (@(posedge pixel_clock_pair_i) disable iff (!rst_n_i) // R1
    s_active_pix |=> $signed(link_reg.disp[0]) <= 5'sh8 && $signed(link_reg.disp[0]) >= -5'sh8
      && blue_lane_o == tmds_encode($past(link_reg.pix.data[7:0]), $signed($past(link_reg.disp[0]))).sym)
    else $error("blue lane symbol or disparity wrong");

  chk_red_lane_map: assert property (@(posedge pixel_clock_pair_i) disable iff (!rst_n_i) // R2
    s_active_pix |=> red_lane_o == tmds_encode($past(link_reg.pix.data[23:16]), $signed($past(link_reg.disp[2]))).sym)
    else $error("red lane not fed from bits 23:16");

  chk_half_word_pair: assert property (@(posedge pixel_clock_pair_i) disable iff (!rst_n_i) // R14
    link_run && link_reg.cfg.edge_rise && !link_reg.cfg.bus24 ##1 link_run |->
      link_reg.pix.data == {$past(fall_reg.data[11:0]), $past(link_reg.rise.data[11:0])})
    else $error("12-bit half words not paired first-low second-high");

  chk_wide_rise_pass: assert property (@(posedge pixel_clock_pair_i) disable iff (!rst_n_i) // R8
    link_run && link_reg.cfg.bus24 && link_reg.cfg.edge_rise ##1 link_run |->
      link_reg.pix == $past(link_reg.rise))
    else $error("24-bit rising capture not passed whole");

  chk_high_swing_se: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R12
    !sys_reg.pins.low_swing |=> !sys_reg.cfg.diff)
    else $error("differential clock chosen in high swing");

  chk_mode_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R11
    sys_reg.pins.low_swing && sys_reg.pins.host_bus && sys_reg.iface[PXMAP_IF_BUS_WIDTH] |=>
      sys_reg.cfg.diff == $past(sys_reg.iface[PXMAP_IF_CLOCK_MODE]))
    else $error("24-bit clock mode decode wrong");

  chk_pin_source: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R13
    !sys_reg.pins.host_bus |=> sys_reg.cfg.bus24 == $past(sys_reg.pins.bus_width)
      && sys_reg.cfg.edge_rise == $past(sys_reg.pins.latch_edge))
    else $error("pin configuration not used with host bus off");

  chk_skew_offset: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R17
    sys_reg.cfg.skew_en |-> skew_offset_o == $signed({1'b0, sys_reg.cfg.skew_code}) - 4'sh4)
    else $error("skew offset is not code minus four");

endmodule // pxmap_top

//--- dv/pxmap_ctrl_model.sv
`timescale 1ns/1ps
module pxmap_ctrl_model
  import pxmap_pkg::*;
(
  input wire pxmap_cap_s pixel_i,
  input wire logic bus24_i,
  input wire logic edge_rise_i,
  output logic lclk_o,
  output logic [23:0] data_o,
  output logic de_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic [2:0] aux_o
);
  // pixel clock runs free, as a controller keeps it up between lines
  initial begin
    lclk_o = 1'b0;
    data_o = 24'h0;
    {de_o, hsync_o, vsync_o, aux_o} = 6'h0;
    #17;
    forever #62.5 lclk_o = ~lclk_o;
  end
  // launch a quarter period after each edge, clear of both capture edges
  always @(lclk_o) begin
    #31;
    if (bus24_i) begin
      data_o = pixel_i.data;
    end else if (lclk_o != edge_rise_i) begin
      data_o = {~data_o[23:12], pixel_i.data[11:0]};
    end else begin
      data_o = {~data_o[23:12], pixel_i.data[23:12]};
    end
    // controls only move with a new pixel
    {de_o, hsync_o, vsync_o, aux_o} = {pixel_i.de, pixel_i.hsync, pixel_i.vsync, pixel_i.aux};
  end
endmodule // pxmap_ctrl_model

//--- dv/pxmap_top_bench.sv
`timescale 1ns/1ps
module pxmap_top_bench
  import pxmap_pkg::*;
;
  logic clock_i, rst_n_i, bus_wr, bus_rd, diff_clock, lclk, de, hs, vs, md24, mdrise, run;
  logic [3:0] bus_addr;
  logic [3:0] sk;
  logic [7:0] bus_wdata, bus_rdata;
  logic signed [3:0] skew_off;
  logic [2:0][9:0] lanes;
  logic [23:0] data;
  logic [2:0] aux;
  logic [31:0] r;
  pxmap_pins_s pins;
  pxmap_cap_s pix;
  int num_errors, cmp_count;
  int tally [3];

  pxmap_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr),
    .bus_wdata_i(bus_wdata), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_rdata_o(bus_rdata),
    .cfg_pins_i(pins), .diff_clock_o(diff_clock), .skew_offset_o(skew_off),
    .pixel_clock_pair_i(lclk), .pix_data_i(data), .pix_de_i(de), .pix_hsync_i(hs),
    .pix_vsync_i(vs), .aux_control_inputs_i(aux), .red_lane_o(lanes[2]),
    .green_lane_o(lanes[1]), .blue_lane_o(lanes[0]));

  pxmap_ctrl_model i_ctrl (.pixel_i(pix), .bus24_i(md24), .edge_rise_i(mdrise), .lclk_o(lclk),
    .data_o(data), .de_o(de), .hsync_o(hs), .vsync_o(vs), .aux_o(aux));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clock_i);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clock_i);
    bus_rd <= 1'b0;
    #1;
    check({16'h0, bus_rdata}, {16'h0, e});
  endtask

  function automatic logic [9:0] ctl(input logic [1:0] c);
    return c[1] ? (c[0] ? PXMAP_CTRL_11 : PXMAP_CTRL_10) : (c[0] ? PXMAP_CTRL_01 : PXMAP_CTRL_00);
  endfunction

  // undo the transition coding to recover the byte
  function automatic logic [7:0] dec(input logic [9:0] s);
    logic [7:0] d;
    logic [7:0] o;
    d = s[9] ? ~s[7:0] : s[7:0];
    o[0] = d[0];
    for (int i = 1; i < 8; i++) o[i] = s[8] ? d[i] ^ d[i-1] : ~(d[i] ^ d[i-1]);
    return o;
  endfunction

  // pixel held five link periods so every capture mode has settled
  task automatic send(input logic [23:0] d, input logic [5:0] c);
    @(posedge clock_i);
    pix <= {d, c};
    repeat (5) @(negedge lclk);
    if (c[5]) begin
      check(24'(dec(lanes[2])), 24'(d[23:16]));
      check(24'(dec(lanes[1])), 24'(d[15:8]));
      check(24'(dec(lanes[0])), 24'(d[7:0]));
    end else begin
      check(24'(lanes[2]), 24'(ctl(c[2:1])));
      check(24'(lanes[1]), 24'(ctl({1'b0, c[0]})));
      check(24'(lanes[0]), 24'(ctl({c[3], c[4]})));
    end
  endtask

  // running ones/zeros tally per lane, cleared by any control symbol
  always @(negedge lclk) begin
    if (run) begin
      for (int i = 0; i < 3; i++) begin
        if (lanes[i] inside {PXMAP_CTRL_00, PXMAP_CTRL_01, PXMAP_CTRL_10, PXMAP_CTRL_11}) tally[i] = 0;
        else tally[i] += 2 * $countones(lanes[i]) - 10;
        check(24'(tally[i] > 16 || tally[i] < -16), 24'h0);
      end
    end
  end

  initial begin
    #100000;
    num_errors++;
    $display("Error at %0t: run did not finish", $time);
    test_done();
  end

  initial begin
    rst_n_i = 1'b0;
    {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    pins = '0;
    pix = '0;
    {md24, mdrise, run} = 3'b110;
    num_errors = 0;
    cmp_count = 0;
    tally = '{0, 0, 0};
    r = $urandom(36713);
    // long enough for the link side to see reset through its synchroniser
    repeat (4) @(posedge lclk);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      @(posedge clock_i);
      pins <= {1'b0, 4'(i), r[3:0]};
      repeat (8) @(posedge clock_i);
      #1;
      sk = r[3] ? r[2:0] + 4'hC : 4'h0;
      check(24'(diff_clock), 24'(i[3] & (i[2] ~^ i[1])));
      check({20'h0, skew_off}, 24'(sk));
      rd(PXMAP_REG_STATUS, {1'b0, i[2], i[0], i[3] & (i[2] ~^ i[1]), r[3:0]});
    end
    @(posedge clock_i);
    pins <= {5'b11110, 4'h0};
    wr(PXMAP_REG_IFACE, 8'h06);
    wr(PXMAP_REG_SKEW, 8'h0B);
    wr(4'h5, 8'hFF);
    repeat (8) @(posedge clock_i);
    rd(PXMAP_REG_IFACE, 8'h06);
    rd(PXMAP_REG_SKEW, 8'h0B);
    rd(4'h5, 8'h00);
    rd(PXMAP_REG_STATUS, 8'h2D);
    check({20'h0, skew_off}, 24'h1);
    check(24'(diff_clock), 24'h0);
    run = 1'b1;
    for (int m = 0; m < 4; m++) begin
      md24 = m[1];
      mdrise = m[0];
      // low swing: keep the clock differential in both widths
      wr(PXMAP_REG_IFACE, {5'h0, m[0], m[1], m[1]});
      repeat (3) @(posedge lclk);
      check(24'(diff_clock), 24'h1);
      for (int k = 0; k < 12; k++) begin
        r = $urandom;
        send(k < 3 ? 24'hFFFFFF : r[23:0], {k < 3 || r[24], r[29:25]});
      end
    end
    test_done();
  end
endmodule // pxmap_top_bench
